// [lcrs_pkg.sv]
// Package with offsets, fields, reset values and timing of the lane configuration slice.
package lcrs_pkg;

  // Byte offsets of the registers in this slice.
  localparam logic [7:0] A_BASE = 8'h34;
  localparam logic [7:0] A_A1_SWING = 8'h34;
  localparam logic [7:0] A_A1_DEEMPH = 8'h35;
  localparam logic [7:0] A_A1_IDLE = 8'h36;
  localparam logic [7:0] A_SPARE_37 = 8'h37;
  localparam logic [7:0] A_SPARE_38 = 8'h38;
  localparam logic [7:0] A_A2_IDLE = 8'h39;
  localparam logic [7:0] A_A2_EQ = 8'h3A;
  localparam logic [7:0] A_A2_SWING = 8'h3B;
  localparam int NREG = 8;

  // Register indices inside the slice.
  localparam logic [2:0] IX_A1_SWING = 3'(A_A1_SWING - A_BASE);
  localparam logic [2:0] IX_A1_DEEMPH = 3'(A_A1_DEEMPH - A_BASE);
  localparam logic [2:0] IX_A1_IDLE = 3'(A_A1_IDLE - A_BASE);
  localparam logic [2:0] IX_A2_IDLE = 3'(A_A2_IDLE - A_BASE);
  localparam logic [2:0] IX_A2_EQ = 3'(A_A2_EQ - A_BASE);
  localparam logic [2:0] IX_A2_SWING = 3'(A_A2_SWING - A_BASE);

  // Values after reset, in slice index order.
  localparam logic [7:0] RST_SWING = 8'hAD;
  localparam logic [7:0] RST_DEEMPH = 8'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h2F;
  localparam logic [7:0] RST_VAL [NREG] = '{RST_SWING, RST_DEEMPH, RST_ZERO, RST_ZERO,
                                            RST_ZERO, RST_ZERO, RST_EQ, RST_SWING};

  // Writable bits of the de-emphasis register; the status bits are read only.
  localparam logic [7:0] WMASK_DEEMPH = 8'h1F;
  localparam logic [7:0] WMASK_FULL = 8'hFF;

  // Field positions.
  localparam int F_SCP = 7;
  localparam int F_RATE = 6;
  localparam int F_SW_LO = 0;
  localparam int F_RXST = 7;
  localparam int F_SPD_LO = 5;
  localparam int F_DEM_LO = 0;
  localparam int F_THA_LO = 2;
  localparam int F_THD_LO = 0;
  localparam int F_IOVR = 5;
  localparam int F_ISEL = 4;
  localparam int F_RXD_LO = 2;

  // Output swing steps in millivolts.
  localparam logic [10:0] SWING_BASE_MV = 11'h2BC;
  localparam logic [10:0] SWING_STEP_MV = 11'h064;

  // Receiver probe timing.
  localparam int CLK_MHZ = 100;
  localparam int PROBE_PERIOD_MS = 12;
  localparam int PROBE_WINDOW_MS = 600;
  localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * 1000 * CLK_MHZ; // Microseconds times cycles per microsecond.
  localparam int PROBE_TRIES = PROBE_WINDOW_MS / PROBE_PERIOD_MS;
  localparam int TMR_W = 21;
  localparam int TRY_W = 6;

  // Receiver-detect modes.
  typedef enum logic [1:0] {
    RXD_HIZ = 2'h0,
    RXD_AUTO_LIM = 2'h1,
    RXD_AUTO_INF = 2'h2,
    RXD_FIX50 = 2'h3
  } lcrs_rxd_mode_t;

  // Probe sequencer states, Gray coded along the probe loop.
  typedef enum logic [2:0] {
    PS_OFF = 3'h0,
    PS_WAIT = 3'h1,
    PS_PROBE = 3'h3,
    PS_FOUND = 3'h2,
    PS_STOP = 3'h7
  } lcrs_probe_state_t;

endpackage

// [lcrs_rxd_if.sv]
// Interface between the register slice and the receiver probe engine.
`timescale 1ns/1ns
interface lcrs_rxd_if;
  logic [1:0] mode;
  logic hit;
  logic probe;
  logic found;
  logic term50;
  logic gave_up;

  // Engine side.
  modport eng(input mode, input hit, output probe, output found, output term50, output gave_up);

  // Register slice side.
  modport ctl(output mode, output hit, input probe, input found, input term50, input gave_up);
endinterface

// [lcrs_rxd_engine.sv]
// Receiver-detect probe engine for one lane.
`timescale 1ns/1ns
module lcrs_rxd_engine #(
  parameter int PERIOD_CYC = lcrs_pkg::PROBE_PERIOD_CYC
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Mode in, probe and termination out.
  lcrs_rxd_if.eng rxd
);
  import lcrs_pkg::*;

  // The wait plus the one probe cycle make up one probe period.
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PERIOD_CYC - 2);
  localparam logic [TRY_W-1:0] TRY_LAST = TRY_W'(PROBE_TRIES - 1);

  lcrs_probe_state_t st_q, st_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TRY_W-1:0] try_q;
  logic [1:0] mode_q;
  logic auto_mode;

  assign auto_mode = (rxd.mode == RXD_AUTO_LIM) || (rxd.mode == RXD_AUTO_INF);

  // Next state; a change of mode restarts the search from the off state.
  always_comb begin
    st_d = st_q;
    case (st_q)
      PS_OFF: if (auto_mode) st_d = PS_WAIT;
      PS_WAIT: if (tmr_q == TMR_LAST) st_d = PS_PROBE; // see (RULE_12) see (RULE_13)
      PS_PROBE: begin
        if (rxd.hit) begin
          st_d = PS_FOUND;
        end else if ((rxd.mode == RXD_AUTO_LIM) && (try_q == TRY_LAST)) begin
          st_d = PS_STOP; // see (RULE_12)
        end else begin
          st_d = PS_WAIT; // see (RULE_13)
        end
      end
      PS_FOUND: st_d = PS_FOUND;
      PS_STOP: st_d = PS_STOP;
      default: st_d = PS_OFF;
    endcase
    if (!auto_mode || (rxd.mode != mode_q)) st_d = PS_OFF;
  end

  // State and last mode seen.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= PS_OFF;
      mode_q <= 2'h0;
    end else begin
      st_q <= st_d;
      mode_q <= rxd.mode;
    end
  end

  // Period timer, running only while waiting.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmr_q <= '0;
    end else if ((st_q == PS_WAIT) && (st_d == PS_WAIT)) begin
      tmr_q <= tmr_q + 1'b1;
    end else begin
      tmr_q <= '0;
    end
  end

  // Attempt counter, cleared whenever the search is off.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      try_q <= '0;
    end else if (st_d == PS_OFF) begin
      try_q <= '0;
    end else if ((st_q == PS_PROBE) && !rxd.hit) begin
      try_q <= try_q + 1'b1; // see (RULE_12)
    end
  end

  // In the automatic modes termination stays high impedance until a receiver is found.
  assign rxd.probe = (st_q == PS_PROBE);
  assign rxd.found = auto_mode && (st_q == PS_FOUND); // see (RULE_14)
  assign rxd.gave_up = (st_q == PS_STOP);
  assign rxd.term50 = (rxd.mode == RXD_FIX50) || (auto_mode && (st_q == PS_FOUND)); // see (RULE_11) see (RULE_14)
endmodule

// [lcrs_slice.sv]
// Configuration and status register slice for lanes A1 and A2 of the repeater.
//
// Operation
// (RULE_01) Swing code bits 2:0 picks 0.7 to 1.4 V in 0.1 V steps; reset 1.2 V.
// (RULE_02) De-emphasis code picks 0 to -12 dB in eight steps; reset -3.5 dB.
// (RULE_03) Rate bit 6 overrides the rate pin: one is gen 1/2, zero gen 3.
// (RULE_04) Software keeps swing bits 5:3 at 101 when writing.
// (RULE_05) De-emphasis bit 7 reads the far receiver detect status, one is detected.
// (RULE_06) Bits 6:5 read the detected lane speed: 2.5, 5 or 8 Gbps.
// (RULE_07) Assert threshold code picks 180, 160, 210, 190 mV; overrides the pin.
// (RULE_08) Deassert threshold code picks 110, 100, 150, 130 mV; overrides the pin.
// (RULE_09) Idle override bit hands idle control to the select bit, else automatic.
// (RULE_10) Under manual control the select bit mutes the lane output.
// (RULE_11) Detect code 00 gives high impedance input, 11 gives fixed 50 ohm.
// (RULE_12) Code 01 probes every 12 ms, at most 50 times, then stops.
// (RULE_13) Code 10 probes every 12 ms until a receiver is found.
// (RULE_14) Automatic modes keep high impedance until detection, then 50 ohm.
// (RULE_15) The detect field overrides the detect pin while registers control the lane.
// (RULE_16) Equalizer register is eight bits, 256 levels, reset 0x2F.
// (RULE_17) Swing bit 7 enables short-circuit protection for its lane.
// (RULE_18) Software writes zero to reserved bits and ignores what they read.
`timescale 1ns/1ns
module lcrs_slice #(
  parameter int P_PROBE_CYC = lcrs_pkg::PROBE_PERIOD_CYC
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port from the serial host engine and the memory loader.
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rd_valid_out,
  // Configuration source and pins.
  input wire logic reg_ctrl_mode_in,
  input wire logic rate_pin_in,
  input wire logic [1:0] signal_threshold_pin_in,
  input wire logic [1:0] far_receiver_detect_pin_in,
  // Lane A1 status from the analog path.
  input wire logic lane_a1_rx_detected_in,
  input wire logic [1:0] lane_a1_detected_speed_status_in,
  // Lane A2 inputs from the analog path.
  input wire logic lane_a2_auto_idle_in,
  input wire logic lane_a2_probe_hit_in,
  // Lane A1 settings.
  output logic [10:0] lane_a1_output_swing_mv_out,
  output logic [6:0] lane_a1_deemphasis_level_out,
  output logic lane_a1_gen12_out,
  output logic lane_a1_short_prot_out,
  output logic [7:0] lane_a1_assert_mv_out,
  output logic [7:0] lane_a1_deassert_mv_out,
  output logic [7:0] lane_a1_speed_out,
  // Lane A2 settings.
  output logic [10:0] lane_a2_output_swing_mv_out,
  output logic lane_a2_gen12_out,
  output logic lane_a2_short_prot_out,
  output logic [7:0] lane_a2_equalizer_level_out,
  output logic lane_a2_mute_out,
  output logic lane_a2_term50_out,
  output logic lane_a2_input_hiz_out,
  output logic lane_a2_probe_out,
  output logic lane_a2_rx_found_out,
  output logic lane_a2_probe_gave_up_out
);
  import lcrs_pkg::*;

  // Swing in millivolts for a three-bit code.
  function automatic logic [10:0] swing_mv(input logic [2:0] code);
    swing_mv = SWING_BASE_MV + (SWING_STEP_MV * 11'(code));
  endfunction

  // De-emphasis in tenths of a decibel of attenuation.
  function automatic logic [6:0] deemph_tenths(input logic [2:0] code);
    case (code)
      3'h0: deemph_tenths = 7'h00;
      3'h1: deemph_tenths = 7'h0F;
      3'h2: deemph_tenths = 7'h23;
      3'h3: deemph_tenths = 7'h32;
      3'h4: deemph_tenths = 7'h3C;
      3'h5: deemph_tenths = 7'h50;
      3'h6: deemph_tenths = 7'h5A;
      default: deemph_tenths = 7'h78;
    endcase
  endfunction

  // Idle assert threshold in millivolts peak to peak.
  function automatic logic [7:0] assert_mv(input logic [1:0] code);
    case (code)
      2'h0: assert_mv = 8'hB4;
      2'h1: assert_mv = 8'hA0;
      2'h2: assert_mv = 8'hD2;
      default: assert_mv = 8'hBE;
    endcase
  endfunction

  // Idle deassert threshold in millivolts peak to peak.
  function automatic logic [7:0] deassert_mv(input logic [1:0] code);
    case (code)
      2'h0: deassert_mv = 8'h6E;
      2'h1: deassert_mv = 8'h64;
      2'h2: deassert_mv = 8'h96;
      default: deassert_mv = 8'h82;
    endcase
  endfunction

  // Detected lane speed in units of 100 Mbps; code 10 is unused and reads zero.
  function automatic logic [7:0] speed_units(input logic [1:0] code);
    case (code)
      2'h0: speed_units = 8'h19;
      2'h1: speed_units = 8'h32;
      2'h3: speed_units = 8'h50;
      default: speed_units = 8'h00;
    endcase
  endfunction

  // True when an address falls inside this slice.
  function automatic logic in_slice(input logic [7:0] addr);
    in_slice = (addr >= A_BASE) && (addr <= A_A2_SWING);
  endfunction

  // Slice index of an address.
  function automatic logic [2:0] slice_index(input logic [7:0] addr);
    slice_index = 3'(addr - A_BASE);
  endfunction

  logic [7:0] regs_q [NREG];
  logic [7:0] rd_word;
  logic [7:0] rdata_q;
  logic rd_valid_q;
  logic wr_hit;
  logic [2:0] wr_index;

  // Effective controls after the pin or register choice.
  logic a1_gen12;
  logic a2_gen12;
  logic [1:0] a1_tha_code;
  logic [1:0] a1_thd_code;
  logic [1:0] a2_rxd_mode;
  logic a2_mute;

  // Write decode shared by every register of the slice.
  assign wr_hit = reg_wr_en_in && in_slice(reg_addr_in);
  assign wr_index = slice_index(reg_addr_in);

  // One storage register per offset; reserved ones store and read back too.
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    localparam logic [7:0] WMASK = (3'(i) == IX_A1_DEEMPH) ? WMASK_DEEMPH : WMASK_FULL;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        regs_q[i] <= RST_VAL[i]; // see (RULE_01) see (RULE_02) see (RULE_16) see (RULE_04)
      end else if (wr_hit && (wr_index == 3'(i))) begin
        regs_q[i] <= (reg_wdata_in & WMASK) | (regs_q[i] & ~WMASK); // see (RULE_18)
      end
    end
  end

  // Read value; live status replaces the read-only bits of the de-emphasis register.
  always_comb begin
    rd_word = 8'h00;
    if (in_slice(reg_addr_in)) begin
      rd_word = regs_q[slice_index(reg_addr_in)];
    end
    if (reg_addr_in == A_A1_DEEMPH) begin
      rd_word[F_RXST] = lane_a1_rx_detected_in; // see (RULE_05)
      rd_word[F_SPD_LO +: 2] = lane_a1_detected_speed_status_in; // see (RULE_06)
    end
  end

  // Read data is captured one cycle after the read strobe.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_rd_en_in;
      if (reg_rd_en_in) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rd_valid_out = rd_valid_q;

  // Register settings win over the pins while registers control the lanes.
  assign a1_gen12 = reg_ctrl_mode_in ? regs_q[IX_A1_SWING][F_RATE] : rate_pin_in; // see (RULE_03)
  assign a2_gen12 = reg_ctrl_mode_in ? regs_q[IX_A2_SWING][F_RATE] : rate_pin_in; // see (RULE_03)
  assign a1_tha_code = reg_ctrl_mode_in ? regs_q[IX_A1_IDLE][F_THA_LO +: 2]
                                        : signal_threshold_pin_in; // see (RULE_07)
  assign a1_thd_code = reg_ctrl_mode_in ? regs_q[IX_A1_IDLE][F_THD_LO +: 2]
                                        : signal_threshold_pin_in; // see (RULE_08)
  assign a2_rxd_mode = reg_ctrl_mode_in ? regs_q[IX_A2_IDLE][F_RXD_LO +: 2]
                                        : far_receiver_detect_pin_in; // see (RULE_15)

  // Manual idle select mutes the output only when the override bit is set.
  assign a2_mute = regs_q[IX_A2_IDLE][F_IOVR] ? regs_q[IX_A2_IDLE][F_ISEL]
                                              : lane_a2_auto_idle_in; // see (RULE_09) see (RULE_10)

  // Receiver probe engine for lane A2.
  lcrs_rxd_if rxd_a2 ();

  assign rxd_a2.mode = a2_rxd_mode; // see (RULE_11)
  assign rxd_a2.hit = lane_a2_probe_hit_in;

  lcrs_rxd_engine #(
    .PERIOD_CYC(P_PROBE_CYC)
  ) u_rxd_a2 (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .rxd(rxd_a2.eng)
  );

  // The probe strobe goes straight out so the analog answer pairs with it.
  assign lane_a2_probe_out = rxd_a2.probe; // see (RULE_12) see (RULE_13)

  // Lane A1 settings out of flip-flops.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lane_a1_output_swing_mv_out <= '0;
      lane_a1_deemphasis_level_out <= '0;
      lane_a1_gen12_out <= 1'b0;
      lane_a1_short_prot_out <= 1'b0;
      lane_a1_assert_mv_out <= '0;
      lane_a1_deassert_mv_out <= '0;
      lane_a1_speed_out <= '0;
    end else begin
      lane_a1_output_swing_mv_out <= swing_mv(regs_q[IX_A1_SWING][F_SW_LO +: 3]); // see (RULE_01)
      lane_a1_deemphasis_level_out <= deemph_tenths(regs_q[IX_A1_DEEMPH][F_DEM_LO +: 3]); // see (RULE_02)
      lane_a1_gen12_out <= a1_gen12;
      lane_a1_short_prot_out <= regs_q[IX_A1_SWING][F_SCP]; // see (RULE_17)
      lane_a1_assert_mv_out <= assert_mv(a1_tha_code); // see (RULE_07)
      lane_a1_deassert_mv_out <= deassert_mv(a1_thd_code); // see (RULE_08)
      lane_a1_speed_out <= speed_units(lane_a1_detected_speed_status_in); // see (RULE_06)
    end
  end

  // Lane A2 settings out of flip-flops.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lane_a2_output_swing_mv_out <= '0;
      lane_a2_gen12_out <= 1'b0;
      lane_a2_short_prot_out <= 1'b0;
      lane_a2_equalizer_level_out <= '0;
      lane_a2_mute_out <= 1'b0;
      lane_a2_term50_out <= 1'b0;
      lane_a2_input_hiz_out <= 1'b1;
      lane_a2_rx_found_out <= 1'b0;
      lane_a2_probe_gave_up_out <= 1'b0;
    end else begin
      lane_a2_output_swing_mv_out <= swing_mv(regs_q[IX_A2_SWING][F_SW_LO +: 3]); // see (RULE_01)
      lane_a2_gen12_out <= a2_gen12;
      lane_a2_short_prot_out <= regs_q[IX_A2_SWING][F_SCP]; // see (RULE_17)
      lane_a2_equalizer_level_out <= regs_q[IX_A2_EQ]; // see (RULE_16)
      lane_a2_mute_out <= a2_mute;
      lane_a2_term50_out <= rxd_a2.term50; // see (RULE_14)
      lane_a2_input_hiz_out <= !rxd_a2.term50; // see (RULE_11)
      lane_a2_rx_found_out <= rxd_a2.found;
      lane_a2_probe_gave_up_out <= rxd_a2.gave_up;
    end
  end
endmodule

// [lcrs_slice_properties.sv]
// Concurrent checks on the ports of the lane configuration slice.
`timescale 1ns/1ns
module lcrs_slice_properties #(
  parameter int P_PROBE_CYC = 10
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port.
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rd_valid_out,
  // Lane status and probe link.
  input wire logic lane_a1_rx_detected_in,
  input wire logic [1:0] lane_a1_detected_speed_status_in,
  input wire logic lane_a2_probe_hit_in,
  input wire logic lane_a2_term50_out,
  input wire logic lane_a2_input_hiz_out,
  input wire logic lane_a2_probe_out,
  input wire logic lane_a2_rx_found_out,
  input wire logic lane_a2_probe_gave_up_out
);
  logic [7:0] gap_q;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // Cycles since the last probe, saturating, so that probe spacing can be judged.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_q <= 8'hFF;
    end else if (lane_a2_probe_out) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // An answered probe, and the detection that must follow it shortly.
  sequence s_hit;
    lane_a2_probe_out && lane_a2_probe_hit_in;
  endsequence
  sequence s_found;
    ##[0:2] lane_a2_rx_found_out;
  endsequence

  // Probe link behaviour.
  a_probe_pulse: assert property (lane_a2_probe_out |=> !lane_a2_probe_out)
    else $error("probe pulse longer than one cycle");
  a_probe_gap: assert property (lane_a2_probe_out |-> gap_q >= 8'(P_PROBE_CYC - 1))
    else $error("probes closer than the probe period");
  a_hit_found: assert property (s_hit |=> s_found)
    else $error("answered probe did not mark the receiver found");
  a_found_terminated: assert property (lane_a2_rx_found_out |-> lane_a2_term50_out && !lane_a2_input_hiz_out)
    else $error("found receiver without 50 ohm termination");
  a_term_quiet: assert property (lane_a2_term50_out |-> !lane_a2_probe_out)
    else $error("probe while input is terminated");
  a_gaveup_quiet: assert property (lane_a2_probe_gave_up_out |-> !lane_a2_probe_out && !lane_a2_rx_found_out)
    else $error("probe after the limited search ended");
  // Register read answers.
  a_read_answer: assert property (reg_rd_en_in |=> reg_rd_valid_out)
    else $error("read without valid one cycle later");
  a_unmapped_zero: assert property (reg_rd_en_in && (reg_addr_in < 8'h34 || reg_addr_in > 8'h3B) |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_status_read: assert property (reg_rd_en_in && reg_addr_in == 8'h35 |=> reg_rdata_out[7:5] ==
    {$past(lane_a1_rx_detected_in), $past(lane_a1_detected_speed_status_in)}) else $error("status bits wrong");
endmodule

bind lcrs_slice lcrs_slice_properties #(.P_PROBE_CYC(P_PROBE_CYC)) props_u (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
  .reg_rdata_out(reg_rdata_out), .reg_rd_valid_out(reg_rd_valid_out), .lane_a1_rx_detected_in(lane_a1_rx_detected_in),
  .lane_a1_detected_speed_status_in(lane_a1_detected_speed_status_in), .lane_a2_probe_hit_in(lane_a2_probe_hit_in),
  .lane_a2_term50_out(lane_a2_term50_out), .lane_a2_input_hiz_out(lane_a2_input_hiz_out),
  .lane_a2_probe_out(lane_a2_probe_out), .lane_a2_rx_found_out(lane_a2_rx_found_out),
  .lane_a2_probe_gave_up_out(lane_a2_probe_gave_up_out));

// [lcrs_host_model.sv]
// Behavioural management host that writes and reads single bytes of the slice.
`timescale 1ns/1ns
module lcrs_host_model (
  // Clock.
  input wire logic core_clk_in,
  // Byte port towards the slice.
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in,
  input wire logic rd_valid_in
);
  // Idle port at time zero.
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // Writes one byte as careful software would and reports the byte sent.
  task automatic write(input logic [7:0] a, input logic [7:0] d, output logic [7:0] s);
    s = d;
    if (a == 8'h34 || a == 8'h3B) s[5:3] = 3'h5;
    if (a == 8'h35) s[4:3] = 2'h0;
    if (a == 8'h36) s[7:4] = 4'h0;
    if (a == 8'h39) s = s & 8'h3C;
    @(posedge core_clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= s;
    @(posedge core_clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~s;
  endtask

  // Reads one byte; the answer is taken mid-cycle after the request, once the registered reply has settled.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge core_clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(negedge core_clk_in);
    d = (rd_valid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the lane configuration slice against a register model.
`timescale 1ns/1ns
module tb;
  localparam int P = 10;
  logic clk, rst_n, wr_en, rd_en, valid, ctrl, rate_pin, det1, idle2, hit2;
  logic g1, sp1, g2, sp2, mute2, t50, hiz, prb, fnd, gup;
  logic [1:0] thr_pin, rxd_pin, spd1;
  logic [7:0] addr, wdata, rdata, as1, ds1, spo1, eq2;
  logic [6:0] dem1;
  logic [10:0] sw1, sw2;
  int failures, num_checks, probes;
  int mdl[8] = '{8'hAD, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'hAD};
  int dem_t[8] = '{0, 15, 35, 50, 60, 80, 90, 120};
  int spd_t[4] = '{25, 50, 0, 80};
  int ath[4] = '{180, 160, 210, 190};
  int dth[4] = '{110, 100, 150, 130};

  lcrs_slice #(.P_PROBE_CYC(P)) dut_u (.core_clk_in(clk), .arst_n_in(rst_n), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rd_valid_out(valid),
    .reg_ctrl_mode_in(ctrl), .rate_pin_in(rate_pin), .signal_threshold_pin_in(thr_pin),
    .far_receiver_detect_pin_in(rxd_pin), .lane_a1_rx_detected_in(det1), .lane_a1_detected_speed_status_in(spd1),
    .lane_a2_auto_idle_in(idle2), .lane_a2_probe_hit_in(hit2), .lane_a1_output_swing_mv_out(sw1),
    .lane_a1_deemphasis_level_out(dem1), .lane_a1_gen12_out(g1), .lane_a1_short_prot_out(sp1),
    .lane_a1_assert_mv_out(as1), .lane_a1_deassert_mv_out(ds1), .lane_a1_speed_out(spo1),
    .lane_a2_output_swing_mv_out(sw2), .lane_a2_gen12_out(g2), .lane_a2_short_prot_out(sp2),
    .lane_a2_equalizer_level_out(eq2), .lane_a2_mute_out(mute2), .lane_a2_term50_out(t50),
    .lane_a2_input_hiz_out(hiz), .lane_a2_probe_out(prb), .lane_a2_rx_found_out(fnd),
    .lane_a2_probe_gave_up_out(gup));
  lcrs_host_model host_u (.core_clk_in(clk), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata), .rd_valid_in(valid));

  // Clock and probe counter.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (prb === 1'b1) probes <= probes + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input int e, input logic [10:0] g);
    num_checks++;
    if (g !== 11'(e)) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // Write through the host and update the model; outputs settle one cycle later.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    host_u.write(a, d, s);
    if (a >= 8'h34 && a <= 8'h3B) mdl[a - 8'h34] = (a == 8'h35) ? (s & 8'h1F) : s;
    tick(2);
  endtask

  task automatic chk_rd(input logic [7:0] a);
    logic [7:0] d;
    logic [7:0] e;
    host_u.read(a, d);
    e = (a >= 8'h34 && a <= 8'h3B) ? 8'(mdl[a - 8'h34]) : 8'h00;
    if (a == 8'h35) e[7:5] = {det1, spd1};
    chk("rdata", e, {3'h0, d});
    tick(1);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    test_done();
  end

  // Main sequence.
  initial begin
    {rst_n, rate_pin, det1, idle2, hit2, thr_pin, rxd_pin, spd1} = '0;
    ctrl = 1'b1;
    probes = 0;
    void'($urandom(32'hFC10));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) chk_rd(8'h34 + 8'(i));
    chk("a1_deemph", 35, {4'h0, dem1});
    chk("a2_eq", 8'h2F, {3'h0, eq2});
    for (int c = 0; c < 8; c++) begin
      wr(8'h34, {2'($urandom), 3'h0, 3'(c)});
      wr(8'h3B, {2'($urandom), 3'h0, 3'(7 - c)});
      chk("a1_swing", 700 + 100 * (mdl[0] % 8), sw1);
      chk("a2_swing", 700 + 100 * (mdl[7] % 8), sw2);
      chk("a1_gen12", mdl[0] / 64 % 2, {10'h0, g1});
      chk("a2_gen12", mdl[7] / 64 % 2, {10'h0, g2});
      chk("a1_prot", mdl[0] / 128, {10'h0, sp1});
      chk("a2_prot", mdl[7] / 128, {10'h0, sp2});
      chk_rd(8'h3B);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      det1 <= 1'($urandom);
      spd1 <= 2'(c % 3) | 2'(c % 3 / 2);
      wr(8'h35, 8'(8'hE0 | c));
      chk("a1_deemph", dem_t[c], {4'h0, dem1});
      chk("a1_speed", spd_t[spd1], {3'h0, spo1});
      chk_rd(8'h35);
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h36, 8'(c));
      chk("a1_assert", ath[c / 4], {3'h0, as1});
      chk("a1_deassert", dth[c % 4], {3'h0, ds1});
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      idle2 <= c[0];
      wr(8'h39, {2'h0, c[2], c[1], 4'h0});
      chk("a2_mute", c[2] ? c[1] : c[0], {10'h0, mute2});
    end
    @(posedge clk);
    ctrl <= 1'b0;
    thr_pin <= 2'($urandom);
    rate_pin <= 1'($urandom);
    rxd_pin <= 2'h3;
    tick(3);
    chk("pin_deassert", dth[thr_pin], {3'h0, ds1});
    chk("pin_gen12", rate_pin, {10'h0, g1});
    chk("pin_term50", 1, {10'h0, t50});
    @(posedge clk);
    ctrl <= 1'b1;
    tick(3);
    chk("reg_hiz", 1, {10'h0, hiz});
    chk("reg_assert", ath[mdl[2] / 4 % 4], {3'h0, as1});
    wr(8'h39, 8'h0C);
    tick(3 * P);
    chk("fix_term50", 1, {10'h0, t50});
    chk("fix_probes", 0, 11'(probes));
    wr(8'h39, 8'h04);
    tick(55 * P);
    chk("lim_probes", 50, 11'(probes));
    chk("lim_gave_up", 1, {10'h0, gup});
    chk("lim_hiz", 1, {10'h0, hiz});
    wr(8'h39, 8'h00);
    probes = 0;
    wr(8'h39, 8'h08);
    for (int i = 0; i < 10 * P && probes < 3; i++) begin
      @(posedge clk);
    end
    hit2 <= 1'b1;
    tick(2 * P);
    chk("inf_probes", 4, 11'(probes));
    chk("inf_found", 1, {10'h0, fnd});
    chk("inf_term50", 1, {10'h0, t50});
    wr(8'h3A, 8'($urandom));
    chk("a2_eq", mdl[6], {3'h0, eq2});
    chk_rd(8'h3A);
    wr(8'h33, 8'h5A);
    chk_rd(8'h33);
    chk_rd(8'h40);
    test_done();
  end
endmodule
